// >>> src/spp_pkg.sv
// package: register map, reset defaults and bus carrier for the shared programmable pins
`default_nettype none
package spp_pkg;
    localparam int NPIN = 48;
    localparam int DW = 16;
    localparam int AW = 5;
    localparam int NWORD = 3;
    localparam int NIRQ = 8;
    // pins able to raise the shared interrupt
    localparam int IRQ_PIN [NIRQ] = '{5, 15, 27, 29, 30, 33, 34, 35};
    // shared interrupt channel number driven by irq_ch_o
    localparam int IRQ_CHANNEL = 14;
    // register groups select by addr[4:2], word within group by addr[1:0]
    localparam logic [2:0] G_GEN = 3'h0;
    localparam logic [2:0] G_DIR = 3'h1;
    localparam logic [2:0] G_PULL = 3'h2;
    localparam logic [2:0] G_DOUT = 3'h3;
    localparam logic [2:0] G_DIN = 3'h4;
    localparam logic [2:0] G_IRQ = 3'h5;
    localparam logic [1:0] W_IRQ_STAT = 2'h0;
    localparam logic [1:0] W_IRQ_CLR = 2'h1;
    localparam logic [1:0] W_IRQ_EN = 2'h2;
    localparam logic [1:0] W_LAST = 2'h2;
    // pins carrying bus-control alternate functions, alternate mode at reset
    localparam logic [NPIN-1:0] CTRL_MASK = 48'h0000_00F0_3E00;
    localparam logic [NPIN-1:0] GEN_RST = ~CTRL_MASK;
    localparam logic [NPIN-1:0] DIR_RST = 48'h0000_0000_0000;
    localparam logic [NPIN-1:0] PULL_RST = 48'hFFFF_FFFF_FFFF;
    localparam logic [NPIN-1:0] DOUT_RST = 48'h0000_0000_0000;
    localparam logic [NIRQ-1:0] IRQ_RST = 8'h00;
    localparam logic SYNC_RST = 1'b1;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } spp_bus_t;
endpackage : spp_pkg
`default_nettype wire

// >>> src/spp_sync.sv
// three-flop input synchroniser with agreement filter
`default_nettype none
module spp_sync (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic d_i,
    output logic q_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_r;
    logic q_nxt;

    // level follows only when second and third stage agree
    assign q_nxt = (s2_r == s3_r) ? s3_r : q_r;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            s1_r <= spp_pkg::SYNC_RST;
            s2_r <= spp_pkg::SYNC_RST;
            s3_r <= spp_pkg::SYNC_RST;
            q_r <= spp_pkg::SYNC_RST;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule // spp_sync
`default_nettype wire

// >>> src/spp_top.sv
// shared programmable pin bank: per-pin mode, direction, pull, data and interrupt
// Notes on behaviour
// - software sets, per pin, general or alternate use, input or output, and pull-up or pull-down.
// - reset gives every pin a fixed default, most pins general inputs with pull-up.
// - only pins 5, 15, 27, 29, 30 and 33 to 35 raise the single shared interrupt on channel 14.
// - pins carrying bus-control signals come out of reset in alternate mode.
`default_nettype none
module spp_top (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire spp_pkg::spp_bus_t bus_i,
    output logic [spp_pkg::DW-1:0] rd_data_o,
    input wire logic [spp_pkg::NPIN-1:0] pin_i,
    output logic [spp_pkg::NPIN-1:0] pin_o,
    output logic [spp_pkg::NPIN-1:0] pin_oen_o,
    output logic [spp_pkg::NPIN-1:0] pull_up_o,
    output logic [spp_pkg::NPIN-1:0] pull_dn_o,
    input wire logic [spp_pkg::NPIN-1:0] alt_out_i,
    input wire logic [spp_pkg::NPIN-1:0] alt_oe_i,
    output logic [spp_pkg::NPIN-1:0] alt_in_o,
    output logic irq_ch_o
);
    localparam int NPIN = spp_pkg::NPIN;
    localparam int DW = spp_pkg::DW;
    localparam int NIRQ = spp_pkg::NIRQ;

    logic [NPIN-1:0] gen_en_r;
    logic [NPIN-1:0] dir_r;
    logic [NPIN-1:0] pull_r;
    logic [NPIN-1:0] dout_r;
    logic [NPIN-1:0] din;
    logic [NPIN-1:0] din_prev_r;
    logic [NPIN-1:0] pin_r;
    logic [NPIN-1:0] pin_nxt;
    logic [NPIN-1:0] oen_r;
    logic [NPIN-1:0] oen_nxt;
    logic [NPIN-1:0] pdn_r;
    logic [NIRQ-1:0] irq_stat_r;
    logic [NIRQ-1:0] irq_stat_nxt;
    logic [NIRQ-1:0] irq_en_r;
    logic [NIRQ-1:0] irq_en_nxt;
    logic [NIRQ-1:0] irq_set;
    logic [NIRQ-1:0] irq_clr;
    logic irq_r;
    logic [DW-1:0] rd_data_r;
    logic [DW-1:0] rd_mux;

    // address decode
    wire [2:0] grp = bus_i.addr[4:2];
    wire [1:0] word = bus_i.addr[1:0];
    wire word_ok = (word <= spp_pkg::W_LAST);
    wire [5:0] lsb = {word, 4'h0};
    wire wr_gen = bus_i.wr && word_ok && (grp == spp_pkg::G_GEN);
    wire wr_dir = bus_i.wr && word_ok && (grp == spp_pkg::G_DIR);
    wire wr_pull = bus_i.wr && word_ok && (grp == spp_pkg::G_PULL);
    wire wr_dout = bus_i.wr && word_ok && (grp == spp_pkg::G_DOUT);
    wire wr_iclr = bus_i.wr && (grp == spp_pkg::G_IRQ) && (word == spp_pkg::W_IRQ_CLR);
    wire wr_ien = bus_i.wr && (grp == spp_pkg::G_IRQ) && (word == spp_pkg::W_IRQ_EN);

    // pin inputs pass the synchroniser before any use
    genvar p;
    generate
        for (p = 0; p < NPIN; p++) begin : g_sync
            spp_sync u_sync (
                .clk_sys_i(clk_sys_i),
                .rstn_i(rstn_i),
                .d_i(pin_i[p]),
                .q_o(din[p])
            );
        end
    endgenerate

    // configuration words, one per sixteen pins
    genvar w;
    generate
        for (w = 0; w < spp_pkg::NWORD; w++) begin : g_word
            always_ff @(posedge clk_sys_i) begin
                if (!rstn_i) begin
                    gen_en_r[w*DW +: DW] <= spp_pkg::GEN_RST[w*DW +: DW];
                    dir_r[w*DW +: DW] <= spp_pkg::DIR_RST[w*DW +: DW];
                    pull_r[w*DW +: DW] <= spp_pkg::PULL_RST[w*DW +: DW];
                    dout_r[w*DW +: DW] <= spp_pkg::DOUT_RST[w*DW +: DW];
                end else if (word == 2'(w)) begin
                    if (wr_gen) begin
                        gen_en_r[w*DW +: DW] <= bus_i.wdata;
                    end
                    if (wr_dir) begin
                        dir_r[w*DW +: DW] <= bus_i.wdata;
                    end
                    if (wr_pull) begin
                        pull_r[w*DW +: DW] <= bus_i.wdata;
                    end
                    if (wr_dout) begin
                        dout_r[w*DW +: DW] <= bus_i.wdata;
                    end
                end
            end
        end
    endgenerate

    assign pin_nxt = (gen_en_r & dout_r) | (~gen_en_r & alt_out_i);
    assign oen_nxt = ~((gen_en_r & dir_r) | (~gen_en_r & alt_oe_i));

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            pin_r <= spp_pkg::DOUT_RST;
            oen_r <= '1;
            pdn_r <= ~spp_pkg::PULL_RST;
            din_prev_r <= {NPIN{spp_pkg::SYNC_RST}};
        end else begin
            pin_r <= pin_nxt;
            oen_r <= oen_nxt;
            pdn_r <= ~pull_r;
            din_prev_r <= din;
        end
    end

    // interrupt events: rising level on a capable general input
    genvar k;
    generate
        for (k = 0; k < NIRQ; k++) begin : g_irq
            localparam int P = spp_pkg::IRQ_PIN[k];
            assign irq_set[k] = din[P] & ~din_prev_r[P] & gen_en_r[P] & ~dir_r[P];

            irq_event_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
                (din[P] && !din_prev_r[P] && gen_en_r[P] && !dir_r[P]) |=> irq_stat_r[k])
                else $error("interrupt event did not set its status bit");
        end
    endgenerate

    assign irq_clr = wr_iclr ? bus_i.wdata[NIRQ-1:0] : '0;
    // set wins over a clear in the same cycle
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
    assign irq_en_nxt = wr_ien ? bus_i.wdata[NIRQ-1:0] : irq_en_r;

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            irq_stat_r <= spp_pkg::IRQ_RST;
            irq_en_r <= spp_pkg::IRQ_RST;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_en_r <= irq_en_nxt;
            irq_r <= |(irq_stat_nxt & irq_en_nxt);
        end
    end

    // read selection, unmapped words read zero
    always_comb begin
        rd_mux = '0;
        if (word_ok) begin
            unique case (grp)
                spp_pkg::G_GEN: rd_mux = gen_en_r[lsb +: DW];
                spp_pkg::G_DIR: rd_mux = dir_r[lsb +: DW];
                spp_pkg::G_PULL: rd_mux = pull_r[lsb +: DW];
                spp_pkg::G_DOUT: rd_mux = dout_r[lsb +: DW];
                spp_pkg::G_DIN: rd_mux = din[lsb +: DW];
                spp_pkg::G_IRQ: begin
                    if (word == spp_pkg::W_IRQ_STAT) begin
                        rd_mux = {{(DW-NIRQ){1'b0}}, irq_stat_r};
                    end else if (word == spp_pkg::W_IRQ_EN) begin
                        rd_mux = {{(DW-NIRQ){1'b0}}, irq_en_r};
                    end
                end
                default: rd_mux = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= bus_i.rd ? rd_mux : '0;
        end
    end

    assign rd_data_o = rd_data_r;
    assign pin_o = pin_r;
    assign pin_oen_o = oen_r;
    assign pull_up_o = pull_r;
    assign pull_dn_o = pdn_r;
    assign alt_in_o = din;
    assign irq_ch_o = irq_r;

    // checks
    reset_defaults_a: assert property (@(posedge clk_sys_i)
        !rstn_i |=> (gen_en_r == spp_pkg::GEN_RST && dir_r == spp_pkg::DIR_RST && pull_r == spp_pkg::PULL_RST))
        else $error("pin configuration not at reset default");

    ctrl_alternate_a: assert property (@(posedge clk_sys_i)
        !rstn_i |=> ((gen_en_r & spp_pkg::CTRL_MASK) == '0))
        else $error("bus-control pin left reset in general mode");

    gen_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_gen && word == 2'h0) |=> (gen_en_r[DW-1:0] == $past(bus_i.wdata)))
        else $error("mode write not stored");

    gen_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        1'b1 |=> ((~pin_oen_o & $past(gen_en_r)) == ($past(dir_r) & $past(gen_en_r))))
        else $error("general pin drive disagrees with direction");

    alt_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        1'b1 |=> ((~pin_oen_o & ~$past(gen_en_r)) == ($past(alt_oe_i) & ~$past(gen_en_r))))
        else $error("alternate pin drive not from peripheral");

    irq_cause_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        irq_ch_o |-> (|(irq_stat_r & irq_en_r)))
        else $error("interrupt high without enabled status");

    read_word_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (bus_i.rd && grp == spp_pkg::G_DIR && word == 2'h1) |=> (rd_data_o == $past(dir_r[2*DW-1:DW])))
        else $error("direction read returned wrong word");

    read_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !bus_i.rd |=> (rd_data_o == '0))
        else $error("read data outside the read answer cycle");

    // register write checks
    dir_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_dir && word == 2'h0) |=> (dir_r[DW-1:0] == $past(bus_i.wdata)))
        else $error("direction write not stored");

    pull_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_pull && word == 2'h1) |=> (pull_r[2*DW-1:DW] == $past(bus_i.wdata)))
        else $error("pull write not stored");

    dout_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_dout && word == 2'h2) |=> (dout_r[3*DW-1:2*DW] == $past(bus_i.wdata)))
        else $error("output data write not stored");

    irq_en_write_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        wr_ien |=> (irq_en_r == $past(bus_i.wdata[NIRQ-1:0])))
        else $error("interrupt enable write not stored");

    // register read checks
    gen_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (bus_i.rd && grp == spp_pkg::G_GEN && word == 2'h0) |=> (rd_data_o == $past(gen_en_r[DW-1:0])))
        else $error("mode read returned wrong word");

    din_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (bus_i.rd && grp == spp_pkg::G_DIN && word == 2'h0) |=> (rd_data_o == $past(din[DW-1:0])))
        else $error("input data read returned wrong word");

    stat_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (bus_i.rd && grp == spp_pkg::G_IRQ && word == spp_pkg::W_IRQ_STAT)
        |=> (rd_data_o[NIRQ-1:0] == $past(irq_stat_r)))
        else $error("status read returned wrong value");

    unmapped_read_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (bus_i.rd && word == 2'h3) |=> (rd_data_o == '0))
        else $error("unmapped word read not zero");

    // pin drive checks
    pin_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rstn_i |=> ((pin_o & $past(gen_en_r)) == ($past(dout_r) & $past(gen_en_r))))
        else $error("general pin level not from output data");

    alt_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rstn_i |=> ((pin_o & ~$past(gen_en_r)) == ($past(alt_out_i) & ~$past(gen_en_r))))
        else $error("alternate pin level not from peripheral");

    pull_split_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        rstn_i |=> (pull_dn_o == ~$past(pull_r)))
        else $error("pull-down select not inverse of pull-up");

    // interrupt status checks
    irq_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (irq_clr[0] && !irq_set[0]) |=> !irq_stat_r[0])
        else $error("status bit not cleared by write");

    irq_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (irq_stat_r[0] && !irq_clr[0]) |=> irq_stat_r[0])
        else $error("status bit lost without clear");

    irq_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (!irq_stat_r[0] && !irq_set[0]) |=> !irq_stat_r[0])
        else $error("status bit set without event");

    irq_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (!gen_en_r[spp_pkg::IRQ_PIN[0]] || dir_r[spp_pkg::IRQ_PIN[0]]) |-> !irq_set[0])
        else $error("event taken on pin not a general input");

    irq_level_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (|(irq_stat_r & irq_en_r)) |-> irq_ch_o)
        else $error("interrupt low with enabled status");

    // reset output checks
    reset_out_a: assert property (@(posedge clk_sys_i)
        !rstn_i |=> (pin_oen_o == '1 && irq_ch_o == 1'b0 && rd_data_o == '0))
        else $error("outputs not at reset level");

    reset_pull_a: assert property (@(posedge clk_sys_i)
        !rstn_i |=> (pull_up_o == spp_pkg::PULL_RST && pull_dn_o == ~spp_pkg::PULL_RST))
        else $error("pull selects not at reset default");
endmodule // spp_top
`default_nettype wire

// >>> verification/spp_board.sv
// board model: external drivers and pull resistors on the shared pins
`default_nettype none
module spp_board (
    input wire logic [spp_pkg::NPIN-1:0] drv_i,
    input wire logic [spp_pkg::NPIN-1:0] oen_i,
    input wire logic [spp_pkg::NPIN-1:0] pull_up_i,
    input wire logic [spp_pkg::NPIN-1:0] ext_en_i,
    input wire logic [spp_pkg::NPIN-1:0] ext_val_i,
    output logic [spp_pkg::NPIN-1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // no emulator fitted, its pins are free
    // device drive, then board driver, then pull
    always_comb begin
        for (int k = 0; k < spp_pkg::NPIN; k++) begin
            if (!oen_i[k]) begin
                level_o[k] = drv_i[k];
            end else if (ext_en_i[k]) begin
                level_o[k] = ext_val_i[k];
            end else begin
                level_o[k] = pull_up_i[k];
            end
        end
    end
endmodule // spp_board
`default_nettype wire

// >>> verification/spp_top_test.sv
// self-checking bench for the shared programmable pin bank
`default_nettype none
module spp_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = spp_pkg::NPIN;
    typedef struct packed {logic [4:0] a; logic [15:0] d; logic [15:0] e;} spp_row_t;
    localparam spp_row_t ROWS [6] = '{'{5'h04, 16'hA5C3, 16'hA5C3}, '{5'h06, 16'h8001, 16'h8001},
        '{5'h09, 16'h0F0F, 16'h0F0F}, '{5'h0D, 16'h1234, 16'h1234}, '{5'h03, 16'hFFFF, 16'h0000},
        '{5'h1F, 16'hFFFF, 16'h0000}};
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    spp_pkg::spp_bus_t bus_i = '0;
    logic [N-1:0] ext_en = '0, ext_val = '0, alt_out = '0, alt_oe = '0;
    logic [N-1:0] pin_i, pin_o, pin_oen_o, pull_up_o, pull_dn_o, alt_in;
    logic [15:0] rd_data_o;
    logic irq_ch_o;
    int error_cnt = 0;
    int checks_done = 0;
    spp_top dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oen_o(pin_oen_o), .pull_up_o(pull_up_o), .pull_dn_o(pull_dn_o),
        .alt_out_i(alt_out), .alt_oe_i(alt_oe), .alt_in_o(alt_in), .irq_ch_o(irq_ch_o));
    spp_board board (.drv_i(pin_o), .oen_i(pin_oen_o), .pull_up_i(pull_up_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .level_o(pin_i));
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic close_out();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [N-1:0] exp, input logic [N-1:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        bus_i <= '0;
    endtask
    task automatic rchk(input string name, input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_sys_i);
        bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys_i);
        bus_i <= '0;
        #1;
        chk(name, {32'h0, e}, {32'h0, rd_data_o});
    endtask
    task automatic drv(input int p, input logic en, input logic v);
        @(posedge clk_sys_i);
        ext_en[p] <= en;
        ext_val[p] <= v;
        tick(8);
    endtask
    initial begin
        #(50 * 20000);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        alt_oe[9] <= 1'b1;
        alt_out[9] <= 1'b1;
        tick(2);
        chk("alt9", 2'b10, {pin_o[9], pin_oen_o[9]});
        wr(5'h16, 16'h00FF);
        for (int k = 0; k < spp_pkg::NIRQ; k++) begin
            drv(spp_pkg::IRQ_PIN[k], 1'b1, 1'b0);
            chk("alt_in", 1'b0, alt_in[spp_pkg::IRQ_PIN[k]]);
            drv(spp_pkg::IRQ_PIN[k], 1'b1, 1'b1);
            chk("irq", 1'b1, irq_ch_o);
            rchk("stat", 5'h14, 16'(1 << k));
            wr(5'h15, 16'(1 << k));
            tick(2);
            chk("irq_clr", 1'b0, irq_ch_o);
            drv(spp_pkg::IRQ_PIN[k], 1'b0, 1'b0);
        end
        drv(6, 1'b1, 1'b0);
        drv(6, 1'b1, 1'b1);
        rchk("stat6", 5'h14, 16'h0000);
        chk("irq6", 1'b0, irq_ch_o);
        wr(5'h16, 16'h0000);
        drv(5, 1'b1, 1'b0);
        drv(5, 1'b1, 1'b1);
        rchk("stat5", 5'h14, 16'h0001);
        chk("irq_mask", 1'b0, irq_ch_o);
        wr(5'h16, 16'h0001);
        tick(2);
        chk("irq_en", 1'b1, irq_ch_o);
        wr(5'h15, 16'h0001);
        drv(5, 1'b0, 1'b0);
        // software turns pin 0 into a driven output
        wr(5'h04, 16'h0001);
        wr(5'h0C, 16'h0001);
        wr(5'h08, 16'hFFFE);
        tick(2);
        chk("oen", 48'hFFFF_FFFF_FDFE, pin_oen_o);
        chk("pull_dn", 48'h0000_0000_0001, pull_dn_o);
        tick(6);
        rchk("din0", 5'h10, 16'hFFFF);
        wr(5'h00, spp_pkg::GEN_RST[15:0] & 16'hFFFD);
        wr(5'h04, 16'h0003);
        @(posedge clk_sys_i);
        alt_oe[1] <= 1'b1;
        alt_out[1] <= 1'b1;
        tick(2);
        chk("alt1_on", 2'b10, {pin_o[1], pin_oen_o[1]});
        @(posedge clk_sys_i);
        alt_oe[1] <= 1'b0;
        tick(2);
        chk("alt1_off", 1'b1, pin_oen_o[1]);
        for (int r = 0; r < 6; r++) begin
            wr(ROWS[r].a, ROWS[r].d);
            rchk("row", ROWS[r].a, ROWS[r].e);
        end
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        alt_oe <= '0;
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        tick(1);
        chk("oen_rst", {N{1'b1}}, pin_oen_o);
        chk("pull_rst", spp_pkg::PULL_RST, pull_up_o);
        for (int w = 0; w < 3; w++) begin
            rchk("gen_rst", 5'(w), spp_pkg::GEN_RST[16 * w +: 16]);
            rchk("dir_rst", 5'(4 + w), 16'h0000);
        end
        close_out();
    end
endmodule // spp_top_test
`default_nettype wire
